/* File: hdl/ama_regs.svh */
/*
  Register offsets, field positions and reset values of the alarm mask aggregator.
  Assumes inclusion by bare name from package and modules.
*/
`ifndef AMA_REGS_SVH
`define AMA_REGS_SVH

`define AMA_ADDR_W           10
`define AMA_DATA_W           8
`define AMA_SUMMARY_ADDR     10'h2C0
`define AMA_STATUS_ADDR      10'h2C1
`define AMA_MASK_ADDR        10'h2C2
`define AMA_SELECT_ADDR      10'h2C3
`define AMA_SRC_N            5
`define AMA_STATUS_RESET     5'h1F
`define AMA_MASK_RESET       8'h1F
`define AMA_RSVD_RESET       3'h0
`define AMA_BIT_DIVIDER      0
`define AMA_BIT_OSC          1
`define AMA_BIT_REALIGN      2
`define AMA_BIT_LINK         3
`define AMA_BIT_LOCK         4
`define AMA_SUMMARY_BIT      0
`define AMA_SEL_BIT          0
`define AMA_SEL_RESET        1'h0
`define AMA_SUMMARY_RESET    1'h0
`define AMA_ZERO8            8'h00

`endif

/* File: hdl/ama_pkg.sv */
/*
  Types shared by the alarm mask aggregator modules.
  Assumes ama_regs.svh is on the include path.
*/
`default_nettype none
`include "ama_regs.svh"

package ama_pkg;
  typedef logic [`AMA_SRC_N-1:0] ama_src_t;
  typedef logic [`AMA_DATA_W-1:0] ama_byte_t;
  typedef logic [`AMA_ADDR_W-1:0] ama_addr_t;
endpackage

`default_nettype wire

/* File: hdl/ama_sticky.sv */
/*
  Five sticky alarm status bits: set by condition, cleared by writing one.
  Assumes conditions are synchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ama_regs.svh"

module ama_sticky
  import ama_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst_n,
  // Conditions and clear
  input  wire ama_src_t cond,
  input  wire ama_src_t clr,
  // State
  output ama_src_t      status
);
  ama_src_t next_status;

  // Set wins over clear in the same cycle
  always_comb begin
    next_status = (status & ~clr) | cond;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= `AMA_STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  sticky_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cond != '0) |=> ((status & $past(cond)) == $past(cond)))
    else $error("Asserted condition did not set status");

  sticky_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clr == '0) |=> ((status & $past(status)) == $past(status)))
    else $error("Status bit dropped without a clear");
endmodule // ama_sticky

`default_nettype wire

/* File: hdl/ama_gate.sv */
/*
  Mask gating and summary formation, registered one cycle.
  Assumes status and mask arrive from registers.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ama_regs.svh"

module ama_gate
  import ama_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst_n,
  // Inputs
  input  wire ama_src_t status,
  input  wire ama_src_t mask,
  // Summary
  output logic          summary
);
  logic next_summary;

  always_comb begin
    next_summary = |(status & ~mask);
  end

  // Registered so a change shows one cycle later
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      summary <= `AMA_SUMMARY_RESET;
    end else begin
      summary <= next_summary;
    end
  end

  summary_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    summary == |($past(status) & ~$past(mask)))
    else $error("Summary does not follow gated status");

  lock_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status[`AMA_BIT_LOCK] && !mask[`AMA_BIT_LOCK]) |=> summary)
    else $error("Unmasked lock alarm missing");

  // Lock alarm pending but masked, nothing else unmasked: summary stays low
  lock_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status[`AMA_BIT_LOCK] && mask[`AMA_BIT_LOCK] && (status & ~mask) == '0) |=> !summary)
    else $error("Masked lock alarm reached summary");

  link_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status[`AMA_BIT_LINK] && !mask[`AMA_BIT_LINK]) |=> summary)
    else $error("Unmasked link alarm missing");

  realign_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status[`AMA_BIT_REALIGN] && !mask[`AMA_BIT_REALIGN]) |=> summary)
    else $error("Unmasked realign alarm missing");

  osc_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status[`AMA_BIT_OSC] && !mask[`AMA_BIT_OSC]) |=> summary)
    else $error("Unmasked phase alarm missing");

  divider_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status[`AMA_BIT_DIVIDER] && !mask[`AMA_BIT_DIVIDER]) |=> summary)
    else $error("Unmasked divider alarm missing");
endmodule // ama_gate

`default_nettype wire

/* File: hdl/ama_top.sv */
/*
  Alarm mask aggregator: status, mask and summary registers with pin routing.
  Assumes a simple synchronous register port on ref_clk (200 MHz).
*/
// Overview of operation
// - Mask bit 4 set keeps the lock-loss alarm out of the summary.
// - Mask bit 3 set keeps the link-not-data alarm out of the summary.
// - Mask bit 2 set keeps the clock-realign alarm out of the summary.
// - Mask bit 1 set keeps the oscillator phase alarm out of the summary.
// - Mask bit 0 set keeps the divider mismatch alarm out of the summary.
// - Mask register at 0x2C2 resets to 0x1F; bits 7..5 read/write, reset zero.
// - Read-only summary bit 0 is one when any unmasked status bit is set.
// - Status bits set by hardware, cleared by writing one; reset all set.
// - A select setting routes the summary onto the calibration status pin.
`timescale 1ns/100ps
`default_nettype none
`include "ama_regs.svh"

module ama_top
  import ama_pkg::*;
(
  // Clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  // Register port
  input  wire ama_addr_t reg_addr,
  input  wire ama_byte_t reg_wdata,
  input  wire logic      reg_wr,
  input  wire logic      reg_rd,
  output ama_byte_t      reg_rdata,
  // Alarm conditions
  input  wire logic      synth_lock_lost_flag,
  input  wire logic      link_not_data_flag,
  input  wire logic      clock_realign_flag,
  input  wire logic      osc_phase_upset_flag,
  input  wire logic      divider_mismatch_flag,
  // Calibration status source and pin
  input  wire logic      cal_done,
  output logic           cal_state_pin,
  // Interrupt
  output logic           irq
);
  ama_src_t  cond;
  ama_src_t  status;
  ama_src_t  clr;
  ama_byte_t alarm_source_mask;
  ama_byte_t next_mask;
  logic      status_sel;
  logic      next_sel;
  logic      summary;
  ama_byte_t next_rdata;
  ama_byte_t status_byte;

  function automatic logic hit(input ama_addr_t a, input ama_addr_t r);
    hit = (a == r);
  endfunction

  always_comb begin
    cond = '0;
    cond[`AMA_BIT_LOCK]    = synth_lock_lost_flag;
    cond[`AMA_BIT_LINK]    = link_not_data_flag;
    cond[`AMA_BIT_REALIGN] = clock_realign_flag;
    cond[`AMA_BIT_OSC]     = osc_phase_upset_flag;
    cond[`AMA_BIT_DIVIDER] = divider_mismatch_flag;
  end

  // Write-one-to-clear only touches the five alarm bits
  always_comb begin
    clr = '0;
    if (reg_wr && hit(reg_addr, `AMA_STATUS_ADDR)) begin
      clr = reg_wdata[`AMA_SRC_N-1:0];
    end
  end

  ama_sticky u_sticky (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cond    (cond),
    .clr     (clr),
    .status  (status)
  );

  ama_gate u_gate (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .status  (status),
    .mask    (alarm_source_mask[`AMA_SRC_N-1:0]),
    .summary (summary)
  );

  // Mask and select registers
  always_comb begin
    next_mask = alarm_source_mask;
    next_sel  = status_sel;
    if (reg_wr && hit(reg_addr, `AMA_MASK_ADDR)) begin
      next_mask = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `AMA_SELECT_ADDR)) begin
      next_sel = reg_wdata[`AMA_SEL_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_source_mask <= `AMA_MASK_RESET;
      status_sel        <= `AMA_SEL_RESET;
    end else begin
      alarm_source_mask <= next_mask;
      status_sel        <= next_sel;
    end
  end

  // Status reserved bits have no storage; read as zero
  always_comb begin
    status_byte = `AMA_ZERO8;
    status_byte[`AMA_SRC_N-1:0] = status;
  end

  // Read data valid the cycle after the strobe only
  always_comb begin
    next_rdata = `AMA_ZERO8;
    if (reg_rd) begin
      case (reg_addr)
        `AMA_SUMMARY_ADDR: next_rdata[`AMA_SUMMARY_BIT] = summary;
        `AMA_STATUS_ADDR:  next_rdata = status_byte;
        `AMA_MASK_ADDR:    next_rdata = alarm_source_mask;
        `AMA_SELECT_ADDR:  next_rdata[`AMA_SEL_BIT] = status_sel;
        default:           next_rdata = `AMA_ZERO8;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `AMA_ZERO8;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Pin and interrupt outputs; summary is already registered
  always_comb begin
    cal_state_pin = status_sel ? summary : cal_done;
    irq           = summary;
  end

  mask_reset_a: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> alarm_source_mask == `AMA_MASK_RESET)
    else $error("Mask not at reset value after reset");

  mask_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `AMA_MASK_ADDR) |=> alarm_source_mask == $past(reg_wdata))
    else $error("Mask write not stored");

  pin_route_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_sel |-> cal_state_pin == summary)
    else $error("Summary not routed to pin");

  sequence unmask_seq;
    status[`AMA_BIT_LOCK] && reg_wr && reg_addr == `AMA_MASK_ADDR
      && !reg_wdata[`AMA_BIT_LOCK];
  endsequence

  unmask_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    unmask_seq |=> ##1 summary)
    else $error("Unmasked pending alarm did not raise summary");

  summary_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `AMA_SUMMARY_ADDR) |=>
      reg_rdata == {7'h00, $past(summary)})
    else $error("Summary read mismatch");

  mask_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `AMA_MASK_ADDR) |=> reg_rdata == $past(alarm_source_mask))
    else $error("Mask read mismatch");

  // Reserved status bits have no storage, so they must read back as zero
  status_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `AMA_STATUS_ADDR) |=>
      reg_rdata == {`AMA_RSVD_RESET, $past(status)})
    else $error("Status read mismatch");

  // A live condition keeps its bit even under a clear
  status_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clr != '0) |=> (status & $past(clr) & ~$past(cond)) == '0)
    else $error("Write-one did not clear status");

  select_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `AMA_SELECT_ADDR) |=>
      reg_rdata[`AMA_SEL_BIT] == $past(status_sel))
    else $error("Select read mismatch");

  pin_cal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !status_sel |-> cal_state_pin == cal_done)
    else $error("Calibration status not on pin");

  // Read data must not linger past its one cycle
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == `AMA_ZERO8)
    else $error("Read data held without a read");
endmodule // ama_top

`default_nettype wire

/* File: dv/ama_tb.sv */
/*
  Self-checking bench for ama_top: register port, mask gating, sticky status, pin routing.
  Assumes ama_pkg and ama_regs.svh are compiled and on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ama_regs.svh"

module testbench
  import ama_pkg::*;
();
  logic      ref_clk;
  logic      rst_n;
  ama_addr_t reg_addr;
  ama_byte_t reg_wdata;
  logic      reg_wr;
  logic      reg_rd;
  ama_byte_t reg_rdata;
  ama_src_t  cond;
  logic      cal_done;
  logic      cal_state_pin;
  logic      irq;
  int        num_errors;
  int        total_checks;

  ama_top u_dut (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .synth_lock_lost_flag (cond[4]),
    .link_not_data_flag   (cond[3]),
    .clock_realign_flag   (cond[2]),
    .osc_phase_upset_flag (cond[1]),
    .divider_mismatch_flag(cond[0]),
    .cal_done             (cal_done),
    .cal_state_pin        (cal_state_pin),
    .irq                  (irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task check(input ama_byte_t seen, input ama_byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Outputs sampled 1 ns after the edge so updates have landed
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task wr(input ama_addr_t a, input ama_byte_t d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input ama_addr_t a, input ama_byte_t e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask

  task pulse(input ama_src_t c);
    @(posedge ref_clk);
    cond <= c;
    @(posedge ref_clk);
    cond <= 5'h00;
    #1;
  endtask

  task t_reset;
    check({7'h00, irq}, 8'h00);
    rd(`AMA_MASK_ADDR, `AMA_MASK_RESET);
    rd(`AMA_STATUS_ADDR, {3'h0, `AMA_STATUS_RESET});
    rd(`AMA_SUMMARY_ADDR, 8'h00);
    rd(`AMA_SELECT_ADDR, 8'h00);
  endtask

  // Each source alone: masked, unmasked, then all others unmasked but it masked
  task t_gate;
    ama_src_t b;
    for (int i = 0; i < `AMA_SRC_N; i++) begin
      b = 5'h01 << i;
      wr(`AMA_MASK_ADDR, 8'h1F);
      wr(`AMA_STATUS_ADDR, 8'h1F);
      pulse(b);
      cyc(1);
      check({7'h00, irq}, 8'h00);
      rd(`AMA_STATUS_ADDR, {3'h0, b});
      wr(`AMA_MASK_ADDR, {3'h0, ~b});
      check({7'h00, irq}, 8'h00);
      cyc(1);
      check({7'h00, irq}, 8'h01);
      rd(`AMA_SUMMARY_ADDR, 8'h01);
      wr(`AMA_MASK_ADDR, {3'h0, b});
      cyc(1);
      check({7'h00, irq}, 8'h00);
    end
    wr(`AMA_MASK_ADDR, 8'h1F);
  endtask

  task t_sticky;
    @(posedge ref_clk);
    cond <= 5'h04;
    wr(`AMA_STATUS_ADDR, 8'h1F);
    rd(`AMA_STATUS_ADDR, 8'h04);
    @(posedge ref_clk);
    cond <= 5'h00;
    wr(`AMA_STATUS_ADDR, 8'h04);
    rd(`AMA_STATUS_ADDR, 8'h00);
    wr(`AMA_SUMMARY_ADDR, 8'hFF);
    rd(`AMA_SUMMARY_ADDR, 8'h00);
    rd(10'h3FF, 8'h00);
    wr(`AMA_MASK_ADDR, 8'hE5);
    rd(`AMA_MASK_ADDR, 8'hE5);
    wr(`AMA_MASK_ADDR, 8'h1F);
  endtask

  // Summary and cal_done held opposite so the wrong source shows
  task t_pin;
    pulse(5'h10);
    wr(`AMA_MASK_ADDR, 8'h0F);
    @(posedge ref_clk);
    cal_done <= 1'b0;
    cyc(1);
    check({7'h00, irq}, 8'h01);
    check({7'h00, cal_state_pin}, 8'h00);
    wr(`AMA_SELECT_ADDR, 8'h01);
    check({7'h00, cal_state_pin}, 8'h01);
    rd(`AMA_SELECT_ADDR, 8'h01);
    wr(`AMA_STATUS_ADDR, 8'h10);
    @(posedge ref_clk);
    cal_done <= 1'b1;
    cyc(1);
    check({7'h00, cal_state_pin}, 8'h00);
    wr(`AMA_SELECT_ADDR, 8'h00);
    check({7'h00, cal_state_pin}, 8'h01);
  endtask

  initial begin
    rst_n        = 1'b0;
    reg_addr     = 10'h000;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    cond         = 5'h00;
    cal_done     = 1'b1;
    num_errors   = 0;
    total_checks = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_gate;
    t_sticky;
    t_pin;
    results;
  end

  // Hang guard, far above the run's length
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    results;
  end
endmodule // testbench
`default_nettype wire
